// [src/emux_regs.svh]
/*
 * register offsets, field positions, reset values and timing counts for
 * the eight line serial multiplexer.
 * assumes a 20 mhz system clock and a 16-bit host bus with byte address.
 */
`ifndef EMUX_REGS_SVH
`define EMUX_REGS_SVH

// byte offsets of the four host words
`define EMUX_OFF_CSR      3'h0
`define EMUX_OFF_SILO     3'h2
`define EMUX_OFF_LINE_EN  3'h4
`define EMUX_OFF_DATASET  3'h6

// control_status_reg field positions
`define EMUX_CSR_MAINT    3
`define EMUX_CSR_CLR      4
`define EMUX_CSR_MSE      5
`define EMUX_CSR_RIE      6
`define EMUX_CSR_RECEIVE_DONE_FLAG    7
`define EMUX_CSR_TRANSMIT_LINE_NUMBER    8
`define EMUX_CSR_SAE      12
`define EMUX_CSR_SA       13
`define EMUX_CSR_TIE      14
`define EMUX_CSR_TRANSMIT_READY_FLAG     15

// receive silo word: valid bit and line field
`define EMUX_SILO_VALID   15
`define EMUX_SILO_LINE    8

// reset values
`define EMUX_BYTE_RST     8'h00
`define EMUX_WORD_RST     16'h0000

// silo alarm threshold and silo depth
`define EMUX_ALARM_COUNT  5'h10
`define EMUX_SILO_DEPTH   16

// timing: clock period and serial bit time, both in ns
`define EMUX_CLK_NS       50
`define EMUX_BIT_NS       104167
`define EMUX_BIT_CYC      (`EMUX_BIT_NS / `EMUX_CLK_NS)
`define EMUX_FRAME_BITS   4'hA

`endif

// [src/emux_pkg.sv]
/*
 * shared types of the eight line serial multiplexer.
 * assumes nothing beyond a systemverilog compiler.
 */
package emux_pkg;
   // line number, eight lines
   typedef logic [2:0] emux_line_t;
   // character as stored in the silo and holding buffers
   typedef logic [7:0] emux_char_t;
   // per-line transmitter state
   typedef enum logic [0:0] {
      EMUX_TX_IDLE  = 1'b0,
      EMUX_TX_SHIFT = 1'b1
   } emux_tx_st_t;
endpackage : emux_pkg

// [src/emux_fifo.sv]
/*
 * generic synchronous fifo with valid/ready on both sides and a flush.
 * assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module emux_fifo #(
   parameter int W = 11,
   parameter int D = 16
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_sys_rst,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   import emux_pkg::*;
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];         // storage array
   logic [AW-1:0] wp, rp;         // write and read pointers
   logic [AW:0]   cnt;            // entries held
   logic [AW-1:0] next_wp, next_rp;
   logic [AW:0]   next_cnt;
   logic          push, pop;

   // ready and valid are flops so back-pressure is glitch free
   assign push = i_in_valid & o_in_ready;
   assign pop  = o_out_valid & i_out_ready;
   assign o_out_data = mem[rp];

   // next pointers and count
   always_comb begin
      next_wp  = push ? wp + 1'b1 : wp;
      next_rp  = pop ? rp + 1'b1 : rp;
      next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      if (i_flush) begin
         next_wp  = '0;
         next_rp  = '0;
         next_cnt = '0;
      end
   end

   // register state and flags
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wp          <= '0;
         rp          <= '0;
         cnt         <= '0;
         o_in_ready  <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         wp          <= next_wp;
         rp          <= next_rp;
         cnt         <= next_cnt;
         o_in_ready  <= (next_cnt != (AW+1)'(D));
         o_out_valid <= (next_cnt != '0);
      end
   end

   // storage written only on an accepted push
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wp] <= i_in_data;
      end
   end
endmodule : emux_fifo
`default_nettype wire

// [src/emux_top.sv]
/*
 * eight line asynchronous serial multiplexer: receive silo with alarm,
 * transmit scanner, per-line double buffered transmitters with break,
 * and data-set control (terminal ready out, carrier and ring in).
 * assumes a host on a 16-bit bus with byte address and byte enables,
 * a receiver front end that delivers whole characters with their line,
 * and asynchronous carrier and ring pins.
 */
//
// Notes on behaviour
// - alarm after 16 characters; access clears it
// - alarm mode: no interrupt below 16 characters
// - without alarm, interrupt on receive done
// - transmit interrupt while ready and enabled
// - silo read returns and removes bottom
// - silo word carries a data valid bit
// - every silo read advances the silo
// - scanner seeks enabled line with empty buffer
// - found line: number, ready, scanner halts
// - data write or enable clear drops ready
// - line 7 highest priority, line 0 lowest
// - byte-wide enable register, word reaches terminal-ready
// - idle line marks; break drives zero
// - break keeps handshake, suppresses line data
// - break ignored in maintenance mode
// - holding buffer feeds shift stage per line
// - terminal ready: reset clears, device clear keeps
// - carrier and ring show present input
// - no data-set interrupts or interlocks
`include "emux_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module emux_top (
   input  wire logic               i_clk_sys,
   input  wire logic               i_sys_rst,
   input  wire logic [2:0]         i_bus_addr,
   input  wire logic               i_bus_wr,
   input  wire logic               i_bus_rd,
   input  wire logic [1:0]         i_bus_be,
   input  wire logic [15:0]        i_bus_wdata,
   output logic [15:0]             o_bus_rdata,
   output logic                    o_bus_ack,
   output logic                    o_rx_irq,
   output logic                    o_tx_irq,
   input  wire logic               i_rx_valid,
   input  wire emux_pkg::emux_line_t i_rx_line,
   input  wire emux_pkg::emux_char_t i_rx_char,
   output logic                    o_rx_ready,
   output logic [7:0]              o_txd,
   output logic [7:0]              o_dtr,
   input  wire logic [7:0]         i_carrier,
   input  wire logic [7:0]         i_ring
);
   import emux_pkg::*;

   // host registers
   logic        maint, master_scan_enable, receive_irq_enable, silo_alarm_enable, transmit_irq_enable;     // control bits
   logic        clr;                           // device clear pulse
   logic [7:0]  line_en;                       // line_enable_reg
   logic [7:0]  dtr;                           // terminal_ready_outputs
   logic [7:0]  line_break_control;                           // line_break_bits
   logic        sa;                            // silo_alarm_flag
   logic [4:0]  sa_cnt;                        // characters since access
   logic        ready;                         // transmit_ready_flag
   emux_line_t  transmit_line_number;                         // transmit_line_number
   logic        next_maint, next_mse, next_rie, next_sae, next_tie, next_clr;
   logic [7:0]  next_line_en, next_dtr, next_brk;
   logic        next_sa;
   logic [4:0]  next_sa_cnt;
   logic        next_ready;
   emux_line_t  next_transmit_line_number;
   logic [15:0] next_rdata;

   // bus decode
   logic wr_csr, wr_en, wr_ds, rd_silo;
   logic transmit_holding_port_wr;                              // transmit_holding_port write
   logic [15:0] csr_word;

   // silo
   logic        silo_push, receive_done_flag;
   logic [10:0] silo_head;

   // transmit side
   logic [7:0]  hold_full;                     // per-line holding buffer full
   logic [7:0]  tx_bit;                        // per-line shifter output
   logic [7:0]  want;                          // lines asking for service
   emux_line_t  pick;                          // highest line asking
   logic [11:0] baud_cnt, next_baud_cnt;       // bit-time divider
   logic        baud_tick, next_baud_tick;

   // pin synchronisers for carrier and ring
   logic [15:0] ds_s1, ds_s2, ds_s3;
   logic [15:0] ds_state, next_ds_state;       // carrier_state_bits, ring

   assign wr_csr  = i_bus_wr & (i_bus_addr[2:1] == `EMUX_OFF_CSR >> 1);
   assign wr_en   = i_bus_wr & (i_bus_addr[2:1] == `EMUX_OFF_LINE_EN >> 1);
   assign wr_ds   = i_bus_wr & (i_bus_addr[2:1] == `EMUX_OFF_DATASET >> 1);
   // any read of the silo word pops, whoever issues it
   assign rd_silo = i_bus_rd & (i_bus_addr[2:1] == `EMUX_OFF_SILO >> 1);
   assign transmit_holding_port_wr = wr_ds & i_bus_be[0];
   assign silo_push = i_rx_valid & o_rx_ready;

   // control word as the host reads it
   always_comb begin
      csr_word = `EMUX_WORD_RST;
      csr_word[`EMUX_CSR_MAINT]             = maint;
      csr_word[`EMUX_CSR_MSE]               = master_scan_enable;
      csr_word[`EMUX_CSR_RIE]               = receive_irq_enable;
      csr_word[`EMUX_CSR_RECEIVE_DONE_FLAG]             = receive_done_flag;
      csr_word[`EMUX_CSR_TRANSMIT_LINE_NUMBER +: 3]        = transmit_line_number;
      csr_word[`EMUX_CSR_SAE]               = silo_alarm_enable;
      csr_word[`EMUX_CSR_SA]                = sa;
      csr_word[`EMUX_CSR_TIE]               = transmit_irq_enable;
      csr_word[`EMUX_CSR_TRANSMIT_READY_FLAG]              = ready;
   end

   // receive silo: 16 characters with their line number
   emux_fifo #(
      .W (11),
      .D (`EMUX_SILO_DEPTH)
   ) u_silo (
      .i_clk_sys   (i_clk_sys),
      .i_sys_rst   (i_sys_rst),
      .i_flush     (clr),
      .i_in_valid  (i_rx_valid),
      .o_in_ready  (o_rx_ready),
      .i_in_data   ({i_rx_line, i_rx_char}),
      .o_out_valid (receive_done_flag),
      // the read removes the bottom entry
      .i_out_ready (rd_silo),
      .o_out_data  (silo_head)
   );

   // host register next values
   always_comb begin
      next_maint   = maint;
      next_mse     = master_scan_enable;
      next_rie     = receive_irq_enable;
      next_sae     = silo_alarm_enable;
      next_tie     = transmit_irq_enable;
      next_clr     = 1'b0;
      next_line_en = line_en;
      next_dtr     = dtr;
      next_brk     = line_break_control;
      next_rdata   = o_bus_rdata;
      if (wr_csr && i_bus_be[0]) begin
         next_maint = i_bus_wdata[`EMUX_CSR_MAINT];
         next_clr   = i_bus_wdata[`EMUX_CSR_CLR];
         next_mse   = i_bus_wdata[`EMUX_CSR_MSE];
         next_rie   = i_bus_wdata[`EMUX_CSR_RIE];
      end
      if (wr_csr && i_bus_be[1]) begin
         next_sae = i_bus_wdata[`EMUX_CSR_SAE];
         next_tie = i_bus_wdata[`EMUX_CSR_TIE];
      end
      // each byte lane alone, a word write reaches both
      if (wr_en && i_bus_be[0]) begin
         next_line_en = i_bus_wdata[7:0];
      end
      if (wr_en && i_bus_be[1]) begin
         next_dtr = i_bus_wdata[15:8];
      end
      if (wr_ds && i_bus_be[1]) begin
         next_brk = i_bus_wdata[15:8];
      end
      // read data, captured in the cycle of the request
      if (i_bus_rd) begin
         case (i_bus_addr[2:1])
            `EMUX_OFF_CSR >> 1: next_rdata = csr_word;
            // valid bit is zero when the silo was empty
            `EMUX_OFF_SILO >> 1:
               next_rdata = {receive_done_flag, 4'h0, receive_done_flag ? silo_head : 11'h000};
            `EMUX_OFF_LINE_EN >> 1: next_rdata = {dtr, line_en};
            // carrier high byte, ring low byte, live state
            default: next_rdata = ds_state;
         endcase
      end
      // device clear leaves terminal ready alone
      if (clr) begin
         next_maint   = 1'b0;
         next_mse     = 1'b0;
         next_rie     = 1'b0;
         next_sae     = 1'b0;
         next_tie     = 1'b0;
         next_line_en = `EMUX_BYTE_RST;
         next_brk     = `EMUX_BYTE_RST;
      end
   end

   // silo alarm counter: a push in a silo-read cycle still counts, one in a device clear cycle does not
   always_comb begin
      next_sa_cnt = sa_cnt;
      next_sa     = sa;
      if (rd_silo || clr) begin
         next_sa_cnt = 5'h00;
         next_sa     = 1'b0;
      end
      if (silo_push && !clr && next_sa_cnt != `EMUX_ALARM_COUNT) begin
         next_sa_cnt = next_sa_cnt + 5'h01;
         if (next_sa_cnt == `EMUX_ALARM_COUNT) begin
            next_sa = 1'b1;
         end
      end
   end

   // ascending loop lets the highest line win
   always_comb begin
      // enabled line with an empty holding buffer
      want = line_en & ~hold_full;
      pick = 3'h0;
      for (int k = 0; k < 8; k++) begin
         if (want[k]) begin
            pick = 3'(k);
         end
      end
   end

   // scanner next values
   always_comb begin
      next_ready = ready;
      next_transmit_line_number = transmit_line_number;
      // scanner parked while master scan is off
      if (clr || !master_scan_enable) begin
         next_ready = 1'b0;
         next_transmit_line_number = 3'h0;
      end else if (ready) begin
         // data written or enable dropped frees the scan
         if (transmit_holding_port_wr || !next_line_en[transmit_line_number]) begin
            next_ready = 1'b0;
         end
      end else if (|want) begin
         // report the line and stop searching
         next_ready = 1'b1;
         next_transmit_line_number = pick;
      end
   end

   // shared bit-time divider, one-cycle tick
   always_comb begin
      next_baud_tick = 1'b0;
      next_baud_cnt  = baud_cnt + 12'h001;
      if (baud_cnt == 12'(`EMUX_BIT_CYC - 1)) begin
         next_baud_cnt  = 12'h000;
         next_baud_tick = 1'b1;
      end
   end

   // a bit changes once the second and third stages agree
   always_comb begin
      next_ds_state = (ds_s2 & ds_s3) | (ds_state & (ds_s2 ^ ds_s3));
   end

   // register the host-facing state
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         maint       <= 1'b0;
         master_scan_enable         <= 1'b0;
         receive_irq_enable         <= 1'b0;
         silo_alarm_enable         <= 1'b0;
         transmit_irq_enable         <= 1'b0;
         clr         <= 1'b0;
         line_en     <= `EMUX_BYTE_RST;
         // only the bus reset clears terminal ready
         dtr         <= `EMUX_BYTE_RST;
         line_break_control         <= `EMUX_BYTE_RST;
         sa          <= 1'b0;
         sa_cnt      <= 5'h00;
         ready       <= 1'b0;
         transmit_line_number       <= 3'h0;
         baud_cnt    <= 12'h000;
         baud_tick   <= 1'b0;
         o_bus_rdata <= `EMUX_WORD_RST;
         o_bus_ack   <= 1'b0;
         o_rx_irq    <= 1'b0;
         o_tx_irq    <= 1'b0;
         o_dtr       <= `EMUX_BYTE_RST;
         ds_s1       <= `EMUX_WORD_RST;
         ds_s2       <= `EMUX_WORD_RST;
         ds_s3       <= `EMUX_WORD_RST;
         ds_state    <= `EMUX_WORD_RST;
      end else begin
         maint       <= next_maint;
         master_scan_enable         <= next_mse;
         receive_irq_enable         <= next_rie;
         silo_alarm_enable         <= next_sae;
         transmit_irq_enable         <= next_tie;
         clr         <= next_clr;
         line_en     <= next_line_en;
         dtr         <= next_dtr;
         line_break_control         <= next_brk;
         sa          <= next_sa;
         sa_cnt      <= next_sa_cnt;
         ready       <= next_ready;
         transmit_line_number       <= next_transmit_line_number;
         baud_cnt    <= next_baud_cnt;
         baud_tick   <= next_baud_tick;
         o_bus_rdata <= next_rdata;
         o_bus_ack   <= i_bus_rd | i_bus_wr;
         // alarm mode waits for the flag; else receive done
         o_rx_irq    <= receive_irq_enable & (silo_alarm_enable ? sa : receive_done_flag);
         // transmit request follows the ready flag
         o_tx_irq    <= transmit_irq_enable & ready;
         // terminal ready pins follow the register
         o_dtr       <= dtr;
         // data-set inputs raise nothing, only synchronised
         ds_s1       <= {i_carrier, i_ring};
         ds_s2       <= ds_s1;
         ds_s3       <= ds_s2;
         ds_state    <= next_ds_state;
      end
   end

   // per-line transmitter: holding buffer, shifter, line pin
   for (genvar g = 0; g < 8; g++) begin : g_line
      emux_tx_st_t st, next_st;
      emux_char_t  hold, next_hold;
      logic        next_full;
      logic [9:0]  sh, next_sh;          // start, 8 data, stop
      logic [3:0]  bits, next_bits;      // bits left in the frame
      logic        next_txd;

      // holding buffer loads the shifter when it goes idle
      always_comb begin
         next_st   = st;
         next_hold = hold;
         next_full = hold_full[g];
         next_sh   = sh;
         next_bits = bits;
         if (st == EMUX_TX_IDLE && hold_full[g]) begin
            next_sh   = {1'b1, hold, 1'b0};
            next_bits = `EMUX_FRAME_BITS;
            next_full = 1'b0;
            next_st   = EMUX_TX_SHIFT;
         end else if (st == EMUX_TX_SHIFT && baud_tick) begin
            next_sh   = {1'b1, sh[9:1]};
            next_bits = bits - 4'h1;
            if (bits == 4'h1) begin
               next_st = EMUX_TX_IDLE;
            end
         end
         // the host writes only the reported line's buffer
         if (transmit_holding_port_wr && transmit_line_number == 3'(g)) begin
            next_hold = i_bus_wdata[7:0];
            next_full = 1'b1;
         end
         if (clr) begin
            next_st   = EMUX_TX_IDLE;
            next_full = 1'b0;
            next_sh   = 10'h3FF;
            next_bits = 4'h0;
         end
         // marking when idle; break hides data only
         if (line_break_control[g] && !maint) begin
            next_txd = 1'b0;
         end else begin
            next_txd = (st == EMUX_TX_SHIFT) ? sh[0] : 1'b1;
         end
      end

      // register the line state and its pin
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            st           <= EMUX_TX_IDLE;
            hold         <= 8'h00;
            hold_full[g] <= 1'b0;
            sh           <= 10'h3FF;
            bits         <= 4'h0;
            o_txd[g]     <= 1'b1;
         end else begin
            st           <= next_st;
            hold         <= next_hold;
            hold_full[g] <= next_full;
            sh           <= next_sh;
            bits         <= next_bits;
            o_txd[g]     <= next_txd;
         end
      end
      assign tx_bit[g] = sh[0];
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   a_alarm_sets: assert property (
      silo_push && !rd_silo && !clr && sa_cnt == 5'h0F |=> sa)
      else $error("alarm not set on sixteenth character");
   a_alarm_clears: assert property (
      rd_silo |=> !sa && sa_cnt <= 5'h01)
      else $error("silo access did not clear alarm");
   a_alarm_irq_gate: assert property (
      receive_irq_enable && silo_alarm_enable && !sa |=> !o_rx_irq)
      else $error("receive interrupt before alarm");
   a_done_irq: assert property (
      receive_irq_enable && !silo_alarm_enable && receive_done_flag |=> o_rx_irq)
      else $error("receive done gave no interrupt");
   a_tx_irq_follow: assert property (
      transmit_irq_enable && ready |=> o_tx_irq)
      else $error("transmit ready gave no interrupt");
   a_silo_valid: assert property (
      rd_silo |=> o_bus_rdata[`EMUX_SILO_VALID] == $past(receive_done_flag))
      else $error("silo valid bit wrong");
   a_scan_holds: assert property (
      ready && master_scan_enable && !clr && !i_bus_wr |=> ready && $stable(transmit_line_number))
      else $error("scanner moved while ready");
   a_scan_prio: assert property (
      !ready && master_scan_enable && !clr && !i_bus_wr && want[7]
      |=> ready && transmit_line_number == 3'h7)
      else $error("line seven not served first");
   a_break_zero: assert property (
      line_break_control[0] && !maint |=> !o_txd[0])
      else $error("break did not drive zero");
   a_scan_off: assert property (
      !master_scan_enable |=> !ready)
      else $error("ready reported with scan disabled");
endmodule : emux_top
`default_nettype wire

// [test/emux_rx_src.sv]
/*
 * receive front-end model: hands whole characters with their line to
 * the multiplexer, valid held until taken or until 100 more cycles pass.
 * assumes the device's ready is a register sampled on the rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module emux_rx_src (
   input  wire logic           i_clk_sys,
   input  wire logic           i_rx_ready,
   output var logic            o_valid,
   output var emux_pkg::emux_line_t o_line,
   output var emux_pkg::emux_char_t o_char
);
   import emux_pkg::*;
   // quiet at time zero so the silo sees nothing before reset ends
   initial begin
      o_valid = 1'b0;
      o_line  = 3'h0;
      o_char  = 8'h00;
   end
   // one beat; released lines show the inverse so stale data never looks valid
   task automatic push(input emux_line_t l, input emux_char_t c, output logic ok);
      int n;
      n = 0;
      o_valid <= 1'b1;
      o_line  <= l;
      o_char  <= c;
      @(posedge i_clk_sys);
      while (i_rx_ready !== 1'b1 && n < 100) begin
         @(posedge i_clk_sys);
         n++;
      end
      // a beat never taken is reported to the caller, not dropped quietly
      ok = (i_rx_ready === 1'b1);
      o_valid <= 1'b0;
      o_line  <= ~l;
      o_char  <= ~c;
      // gap cycle keeps two pushes from driving one edge twice
      @(posedge i_clk_sys);
   endtask : push
endmodule : emux_rx_src
`default_nettype wire

// [test/testbench.sv]
/*
 * self-checking bench of the serial multiplexer: bus tasks, xorshift
 * stimulus, expectations worked out here.
 * assumes emux_top and the front-end model emux_rx_src.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import emux_pkg::*;
   logic        i_clk_sys, i_sys_rst, i_bus_wr, i_bus_rd;
   logic [2:0]  i_bus_addr;
   logic [1:0]  i_bus_be;
   logic [15:0] i_bus_wdata, o_bus_rdata;
   logic        o_bus_ack, o_rx_irq, o_tx_irq, rx_valid, rx_ready;
   emux_line_t  rx_line;
   emux_char_t  rx_char;
   logic [7:0]  o_txd, o_dtr, i_carrier, i_ring;
   logic [31:0] seed = 32'h0000_0061;   // fixed start keeps runs repeatable
   logic [15:0] exp_q[$];               // silo words still to be read
   int          bad_count = 0, checked = 0, cycles = 0;

   emux_top u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_bus_addr(i_bus_addr),
      .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd), .i_bus_be(i_bus_be), .i_bus_wdata(i_bus_wdata),
      .o_bus_rdata(o_bus_rdata), .o_bus_ack(o_bus_ack), .o_rx_irq(o_rx_irq),
      .o_tx_irq(o_tx_irq), .i_rx_valid(rx_valid), .i_rx_line(rx_line), .i_rx_char(rx_char),
      .o_rx_ready(rx_ready), .o_txd(o_txd), .o_dtr(o_dtr), .i_carrier(i_carrier),
      .i_ring(i_ring));
   emux_rx_src u_src (.i_clk_sys(i_clk_sys), .i_rx_ready(rx_ready), .o_valid(rx_valid),
      .o_line(rx_line), .o_char(rx_char));

   // 50 ns clock
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask : done
   // one strobe cycle, then wait for the ack edge and take the data there
   task automatic bus(input logic w, input logic [2:0] a, input logic [1:0] be,
                      input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      i_bus_wr    <= w;
      i_bus_rd    <= ~w;
      i_bus_addr  <= a;
      i_bus_be    <= be;
      i_bus_wdata <= d;
      @(posedge i_clk_sys);
      i_bus_wr <= 1'b0;
      i_bus_rd <= 1'b0;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_bus_ack !== 1'b1 && n < 8);
      chk("ack", 16'h0001, {15'h0000, o_bus_ack});
      q = o_bus_rdata;
   endtask : bus
   task automatic feed(input int n);
      logic [31:0] r;
      logic        ok;
      for (int i = 0; i < n; i++) begin
         r = xs();
         u_src.push(r[2:0], r[15:8], ok);
         chk("rx_take", 16'h0001, {15'h0000, ok});
         exp_q.push_back({1'b1, 4'h0, r[2:0], r[15:8]});
      end
   endtask : feed
   task automatic drain(input int n);
      logic [15:0] q;
      for (int i = 0; i < n; i++) begin
         tick(20);
         bus(1'b0, 3'h2, 2'b11, 16'h0000, q);
         chk("silo", exp_q.pop_front(), q);
      end
   endtask : drain
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict

   initial begin
      logic [15:0] q;
      logic [31:0] r;
      {i_sys_rst, i_bus_wr, i_bus_rd, i_bus_addr, i_bus_be} = 8'h80;
      {i_bus_wdata, i_carrier, i_ring} = 32'h0000_0000;
      tick(3);
      i_sys_rst <= 1'b0;
      tick(1);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("ctrl", 16'h0000, q);
      chk("txd", 16'h00FF, {8'h00, o_txd});
      done("reset");
      r = xs();
      i_carrier <= r[15:8];
      i_ring    <= r[7:0];
      tick(5);
      bus(1'b0, 3'h6, 2'b11, 16'h0000, q);
      chk("dataset", r[15:0], q);
      r = xs();
      bus(1'b1, 3'h4, 2'b11, r[15:0], q);
      bus(1'b0, 3'h4, 2'b11, 16'h0000, q);
      chk("enable", r[15:0], q);
      chk("dtr", {8'h00, r[15:8]}, {8'h00, o_dtr});
      bus(1'b1, 3'h0, 2'b01, 16'h0010, q);
      tick(3);
      bus(1'b0, 3'h4, 2'b11, 16'h0000, q);
      chk("dev_clear", {r[15:8], 8'h00}, q);
      done("dataset");
      // lines 7 and 0 both want service; 7 must come first
      bus(1'b1, 3'h0, 2'b11, 16'h4020, q);
      bus(1'b1, 3'h4, 2'b01, 16'h0081, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("scan", 16'hC720, q);
      chk("tx_irq", 16'h0001, {15'h0000, o_tx_irq});
      bus(1'b1, 3'h6, 2'b01, 16'h0055, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      // line 7's buffer is full for a cycle, so line 0 is found first
      chk("other_line", 16'hC020, q);
      bus(1'b1, 3'h6, 2'b01, 16'h0000, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      // line 7 is asked again while its shifter still sends
      chk("reload", 16'hC720, q);
      bus(1'b1, 3'h4, 2'b01, 16'h0001, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("next_line", 16'hC020, q);
      // break on line 0 and on idle line 3, which shows the change
      bus(1'b1, 3'h6, 2'b10, 16'h0900, q);
      tick(3);
      chk("break", 16'h0000, {15'h0000, o_txd[3]});
      bus(1'b1, 3'h6, 2'b01, 16'h0000, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("held", 16'h4020, q);
      bus(1'b1, 3'h0, 2'b01, 16'h0028, q);
      tick(2);
      chk("maint", 16'h0001, {15'h0000, o_txd[3]});
      bus(1'b1, 3'h6, 2'b10, 16'h0000, q);
      bus(1'b1, 3'h0, 2'b11, 16'h4000, q);
      tick(4);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("scan_off", 16'h4000, q & 16'hF8FF);
      done("scanner");
      bus(1'b1, 3'h0, 2'b11, 16'h0040, q);
      feed(3);
      tick(3);
      chk("rx_irq", 16'h0001, {15'h0000, o_rx_irq});
      drain(3);
      tick(20);
      bus(1'b0, 3'h2, 2'b11, 16'h0000, q);
      chk("empty", 16'h0000, q & 16'h8000);
      done("silo");
      bus(1'b1, 3'h0, 2'b11, 16'h1040, q);
      feed(15);
      tick(3);
      chk("no_alarm", 16'h0000, {15'h0000, o_rx_irq});
      feed(1);
      tick(3);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("alarm", 16'h30C0, q & 16'hF8FF);
      chk("alarm_irq", 16'h0001, {15'h0000, o_rx_irq});
      drain(1);
      tick(3);
      bus(1'b0, 3'h0, 2'b11, 16'h0000, q);
      chk("alarm_clr", 16'h10C0, q & 16'hF8FF);
      drain(15);
      done("alarm");
      // bus initialize in mid-run must clear terminal ready
      bus(1'b1, 3'h4, 2'b10, 16'hFF00, q);
      i_sys_rst <= 1'b1;
      tick(3);
      i_sys_rst <= 1'b0;
      tick(1);
      bus(1'b0, 3'h4, 2'b11, 16'h0000, q);
      chk("dtr_init", 16'h0000, q);
      chk("dtr_pin", 16'h0000, {8'h00, o_dtr});
      done("init");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
